// ==== rtl/icr_config_regs.sv ====
// indexed configuration register bank with memory steering
`timescale 1ns/1ns

module icr_config_regs #(
    parameter logic [5:0] PART_CODE       = 6'h2a,  // arbitrary value
    parameter logic [1:0] SILICON_VERSION = 2'h1    // arbitrary value
) (
    input  wire logic                 CLK_SYS,
    input  wire logic                 RST_N,
    input  wire icr_pkg::icr_io_req_s IO_REQ,
    output logic [7:0]                IO_RDATA,
    output logic                      IO_RDATA_VALID,
    input  wire icr_pkg::icr_mem_req_s MEM_REQ,
    input  wire logic [7:0]           SHADOW_E_SEGMENT,
    output logic                      ROM_CHIP_SELECT_N,
    output logic                      SLOT_BUS_SEL,
    output logic                      BOARD_SEL,
    input  wire logic [3:0]           RAS_BANK_STROBE_INT_N,
    output logic [3:0]                RAS_BANK_STROBE_N,
    output icr_pkg::icr_cfg_s         CFG
);

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [7:0]       index_r;
    logic [7:0]       cfg_r [0:icr_pkg::REG_COUNT-1];
    logic             io_hit_index;
    logic             io_hit_data;
    logic             idx_mapped;
    logic [7:0]       read_value;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (icr_pkg::REG_COUNT < 14 || icr_pkg::REG_COUNT > 16)
    begin : g_bad_reg_count
        $error("register count does not fit the four-bit index slice");
    end

    // ****************************************************************
    // port decode
    // ****************************************************************
    function automatic logic port_match(input logic [15:0] addr, input logic [15:0] port,
                                        input logic short_decode);
        if (short_decode)
            port_match = (addr & icr_pkg::IO_SHORT_MASK) == port;
        else
            port_match = addr == port;
    endfunction : port_match

    assign io_hit_index = port_match(IO_REQ.addr, icr_pkg::IO_INDEX_ADDR,
                                     CFG.io_decode_10);
    assign io_hit_data  = port_match(IO_REQ.addr, icr_pkg::IO_DATA_ADDR,
                                     CFG.io_decode_10);
    assign idx_mapped   = index_r < 8'(icr_pkg::REG_COUNT);

    // ****************************************************************
    // index port
    // ****************************************************************
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            index_r <= 8'h00;
        else if (IO_REQ.wr && io_hit_index)
            index_r <= IO_REQ.wdata;
    end

    // ****************************************************************
    // indexed registers, byte writes through the data port
    // ****************************************************************
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            for (int i = 0; i < icr_pkg::REG_COUNT; i++)
                cfg_r[i] <= icr_pkg::reg_reset(8'(i));
        end
        else if (IO_REQ.wr && io_hit_data && idx_mapped)
        begin
            // host writes single bytes only
            cfg_r[index_r[3:0]] <= (IO_REQ.wdata & icr_pkg::reg_wmask(index_r))
                                 | (cfg_r[index_r[3:0]] & ~icr_pkg::reg_wmask(index_r));
        end
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    always_comb
    begin
        if (io_hit_index)
            read_value = index_r;
        else if (!idx_mapped)
            read_value = icr_pkg::UNMAPPED_READ;
        else if (index_r == icr_pkg::IDX_PART_ID)
            read_value = {PART_CODE, SILICON_VERSION};
        else
            read_value = (cfg_r[index_r[3:0]] & icr_pkg::reg_wmask(index_r))
                       | ~icr_pkg::reg_wmask(index_r);
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            IO_RDATA       <= 8'h00;
            IO_RDATA_VALID <= 1'b0;
        end
        else
        begin
            IO_RDATA_VALID <= IO_REQ.rd && (io_hit_index || io_hit_data);
            if (IO_REQ.rd && (io_hit_index || io_hit_data))
                IO_RDATA <= read_value;
        end
    end

    // ****************************************************************
    // configuration fields
    // ****************************************************************
    function automatic icr_pkg::icr_timing_s timing_fields(input logic [7:0] ras,
                                                           input logic [7:0] cas);
        timing_fields.ras_addsel = ras[7];
        timing_fields.trcd_long  = ras[6];
        timing_fields.trp        = ras[4:3];
        timing_fields.tras       = ras[2:0];
        timing_fields.tcasw      = cas[7:6];
        timing_fields.tcst_long  = cas[5];
        timing_fields.tcp        = cas[4:3];
        timing_fields.tcasr      = cas[1:0];
    endfunction : timing_fields

    always_comb
    begin
        CFG.slot_boundary = cfg_r[icr_pkg::IDX_SLOT_BOUNDARY[3:0]];
        CFG.rom_slot      = cfg_r[icr_pkg::IDX_DRAM_MAP[3:0]][icr_pkg::MAP_ROM_SLOT_BIT];
        CFG.map_code      = cfg_r[icr_pkg::IDX_DRAM_MAP[3:0]][4:0];
        CFG.dram_drive    = cfg_r[icr_pkg::IDX_DRAM_SETUP[3:0]][7:6];
        CFG.early_start_n = cfg_r[icr_pkg::IDX_DRAM_SETUP[3:0]][icr_pkg::SET_EARLY_BIT];
        CFG.page_a        = cfg_r[icr_pkg::IDX_DRAM_SETUP[3:0]][3];
        CFG.page_b        = cfg_r[icr_pkg::IDX_DRAM_SETUP[3:0]][2];
        CFG.ilv_a         = cfg_r[icr_pkg::IDX_DRAM_SETUP[3:0]][1];
        CFG.ilv_b         = cfg_r[icr_pkg::IDX_DRAM_SETUP[3:0]][0];
        CFG.ref_decoupled = cfg_r[icr_pkg::IDX_REFRESH_CTL[3:0]][icr_pkg::REF_DECUP_BIT];
        CFG.ref_div_board = cfg_r[icr_pkg::IDX_REFRESH_CTL[3:0]][6:4];
        CFG.io_decode_10  = cfg_r[icr_pkg::IDX_REFRESH_CTL[3:0]][icr_pkg::REF_IO10_BIT];
        CFG.ref_div_slot  = cfg_r[icr_pkg::IDX_REFRESH_CTL[3:0]][2:0];
        CFG.timing_low    = timing_fields(cfg_r[icr_pkg::IDX_RAS_TIM_LOW[3:0]],
                                          cfg_r[icr_pkg::IDX_CAS_TIM_LOW[3:0]]);
        CFG.timing_high   = timing_fields(cfg_r[icr_pkg::IDX_RAS_TIM_HIGH[3:0]],
                                          cfg_r[icr_pkg::IDX_CAS_TIM_HIGH[3:0]]);
        CFG.ems_global    = cfg_r[icr_pkg::IDX_EMS_UPPER[3:0]][icr_pkg::EMS_GLOBAL_BIT];
        CFG.ems_backfill  = cfg_r[icr_pkg::IDX_EMS_UPPER[3:0]][icr_pkg::EMS_BACKFILL_BIT];
        CFG.ems_map       = cfg_r[icr_pkg::IDX_EMS_UPPER[3:0]][icr_pkg::EMS_MAP_BIT];
        CFG.ems_page_en   = {cfg_r[icr_pkg::IDX_EMS_UPPER[3:0]][3:0],
                             cfg_r[icr_pkg::IDX_EMS_LOWER[3:0]]};
        CFG.shadow_a      = cfg_r[icr_pkg::IDX_SHADOW_A[3:0]];
    end

    // ****************************************************************
    // memory steering
    // ****************************************************************
    logic       rom_nxt;
    logic       slot_nxt;
    logic       board_nxt;
    logic [1:0] shadow_field;
    logic       dflt_rom;
    logic [7:0] seg;

    assign seg = MEM_REQ.addr[23:16];

    always_comb
    begin
        shadow_field = 2'b00;
        dflt_rom     = 1'b0;
        rom_nxt      = 1'b0;
        slot_nxt     = 1'b0;
        board_nxt    = 1'b0;
        if (seg == icr_pkg::SEG_A)
            shadow_field = CFG.shadow_a[2*MEM_REQ.addr[15:14] +: 2];
        else if (seg == icr_pkg::SEG_E)
            shadow_field = SHADOW_E_SEGMENT[2*MEM_REQ.addr[15:14] +: 2];
        if (seg == icr_pkg::SEG_F)
            dflt_rom = 1'b1;
        else if (seg == icr_pkg::SEG_E || seg == icr_pkg::SEG_FE)
            dflt_rom = CFG.rom_slot;
        if (seg == icr_pkg::SEG_FE)
        begin
            rom_nxt  = MEM_REQ.rd && CFG.rom_slot;
            slot_nxt = MEM_REQ.wr || (MEM_REQ.rd && !CFG.rom_slot);
        end
        else if (seg >= icr_pkg::SEG_A && seg <= icr_pkg::SEG_F && seg != icr_pkg::SEG_B)
        begin
            // reads: bit 1 selects board, else default target
            rom_nxt   = MEM_REQ.rd && !shadow_field[1] && dflt_rom;
            slot_nxt  = (MEM_REQ.rd && !shadow_field[1] && !dflt_rom)
                      || (MEM_REQ.wr && !shadow_field[0]);
            board_nxt = (MEM_REQ.rd && shadow_field[1])
                      || (MEM_REQ.wr && shadow_field[0]);
        end
        else if (seg == icr_pkg::SEG_B)
            slot_nxt  = MEM_REQ.rd || MEM_REQ.wr;
        else
        begin
            slot_nxt  = (MEM_REQ.rd || MEM_REQ.wr) && seg >= CFG.slot_boundary;
            board_nxt = (MEM_REQ.rd || MEM_REQ.wr) && seg < CFG.slot_boundary;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ROM_CHIP_SELECT_N <= 1'b1;
            SLOT_BUS_SEL      <= 1'b0;
            BOARD_SEL         <= 1'b0;
        end
        else
        begin
            ROM_CHIP_SELECT_N <= !rom_nxt;
            SLOT_BUS_SEL      <= slot_nxt;
            BOARD_SEL         <= board_nxt;
        end
    end

    // ****************************************************************
    // bank strobe swap
    // ****************************************************************
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            RAS_BANK_STROBE_N <= 4'hf;
        else
        begin
            for (int p = 0; p < 4; p++)
                RAS_BANK_STROBE_N[p] <= RAS_BANK_STROBE_INT_N[
                    icr_pkg::swap_select(cfg_r[icr_pkg::IDX_RAS_SWAP[3:0]][3:0], 2'(p))];
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    chk_index_readback: assert property (
        (IO_REQ.wr && io_hit_index) ##1 !(IO_REQ.wr && io_hit_index)
        ##1 (IO_REQ.rd && io_hit_index)
        |=> IO_RDATA == $past(IO_REQ.wdata, 3))
        else $error("index port read-back wrong");

    chk_ident_value: assert property (
        (IO_REQ.rd && io_hit_data && !io_hit_index && index_r == icr_pkg::IDX_PART_ID)
        |=> IO_RDATA_VALID && IO_RDATA == {PART_CODE, SILICON_VERSION})
        else $error("identification read wrong");

    chk_ones_readback: assert property (
        (IO_REQ.rd && io_hit_data && !io_hit_index && index_r == icr_pkg::IDX_DRAM_MAP)
        |=> IO_RDATA[6:5] == 2'b11)
        else $error("unused bits not one");

    chk_ro_ignored: assert property (
        (IO_REQ.wr && io_hit_data && index_r == icr_pkg::IDX_RAS_SWAP)
        |=> cfg_r[icr_pkg::IDX_RAS_SWAP[3:0]][7:4] == $past(cfg_r[icr_pkg::IDX_RAS_SWAP[3:0]][7:4]))
        else $error("read-only bits changed");

    chk_data_write: assert property (
        (IO_REQ.wr && io_hit_data && index_r == icr_pkg::IDX_SLOT_BOUNDARY)
        |=> CFG.slot_boundary == $past(IO_REQ.wdata))
        else $error("data port write lost");

    chk_e_rom_read: assert property (
        (MEM_REQ.rd && seg == icr_pkg::SEG_E && CFG.rom_slot && shadow_field == 2'b00)
        |=> !ROM_CHIP_SELECT_N && !SLOT_BUS_SEL)
        else $error("e-segment rom read not selected");

    chk_fe_slot: assert property (
        (MEM_REQ.rd && seg == icr_pkg::SEG_FE && !CFG.rom_slot)
        |=> ROM_CHIP_SELECT_N && SLOT_BUS_SEL)
        else $error("fe range not sent to slot");

    chk_shadow_board: assert property (
        (MEM_REQ.wr && seg == icr_pkg::SEG_A && shadow_field[0])
        |=> BOARD_SEL && !SLOT_BUS_SEL)
        else $error("shadow write not on board");

    chk_slot_boundary: assert property (
        ((MEM_REQ.rd || MEM_REQ.wr) && seg > icr_pkg::SEG_F && seg != icr_pkg::SEG_FE
         && seg >= CFG.slot_boundary) |=> SLOT_BUS_SEL && !BOARD_SEL)
        else $error("boundary not honoured");

    chk_long_decode: assert property (
        (IO_REQ.wr && !CFG.io_decode_10 && IO_REQ.addr[15:10] != 6'h00)
        |=> $stable(index_r))
        else $error("alias decoded in 16-bit mode");

    chk_reset_values: assert property (
        $rose(RST_N) |-> index_r == 8'h00
        && CFG.slot_boundary == 8'hff
        && cfg_r[icr_pkg::IDX_DRAM_MAP[3:0]] == 8'he0
        && cfg_r[icr_pkg::IDX_RAS_SWAP[3:0]] == 8'hf0
        && cfg_r[icr_pkg::IDX_DRAM_SETUP[3:0]] == 8'h3c
        && cfg_r[icr_pkg::IDX_CAS_TIM_LOW[3:0]] == 8'hb7)
        else $error("defaults not restored");

    chk_strobe_identity: assert property (
        cfg_r[icr_pkg::IDX_RAS_SWAP[3:0]][3:0] == 4'h0
        |=> RAS_BANK_STROBE_N == $past(RAS_BANK_STROBE_INT_N))
        else $error("identity swap code moved strobes");

    chk_index_write: assert property (
        (IO_REQ.wr && io_hit_index)
        |=> index_r == $past(IO_REQ.wdata))
        else $error("index port write lost");

    chk_rdata_hold: assert property (
        !IO_REQ.rd
        |=> $stable(IO_RDATA) && !IO_RDATA_VALID)
        else $error("read data moved without a read");

    chk_unmapped_read: assert property (
        (IO_REQ.rd && io_hit_data && !io_hit_index && !idx_mapped)
        |=> IO_RDATA == 8'hff)
        else $error("unmapped index not read as ones");

    chk_f_rom_read: assert property (
        (MEM_REQ.rd && seg == icr_pkg::SEG_F)
        |=> !ROM_CHIP_SELECT_N && !BOARD_SEL)
        else $error("f-segment default read not from rom");

    chk_a_page_read: assert property (
        (MEM_REQ.rd && seg == icr_pkg::SEG_A && MEM_REQ.addr[15:14] == 2'd1
         && CFG.shadow_a[3])
        |=> BOARD_SEL && ROM_CHIP_SELECT_N)
        else $error("a-segment page pair not decoded");

    chk_fe_write: assert property (
        (MEM_REQ.wr && seg == icr_pkg::SEG_FE)
        |=> SLOT_BUS_SEL && ROM_CHIP_SELECT_N)
        else $error("fe range write not sent to slot");

    chk_board_below: assert property (
        ((MEM_REQ.rd || MEM_REQ.wr) && seg > icr_pkg::SEG_F && seg != icr_pkg::SEG_FE
         && seg < CFG.slot_boundary)
        |=> BOARD_SEL && !SLOT_BUS_SEL)
        else $error("access below boundary left the board");

    cov_index_write: cover property (IO_REQ.wr && io_hit_index);
    cov_data_read:   cover property (IO_REQ.rd && io_hit_data ##1 IO_RDATA_VALID);
    cov_rom_select:  cover property (!ROM_CHIP_SELECT_N);
    cov_board_sel:   cover property (BOARD_SEL && $past(seg == icr_pkg::SEG_A));
    cov_slot_sel:    cover property (SLOT_BUS_SEL && $past(seg) > icr_pkg::SEG_F);

endmodule : icr_config_regs

// ==== rtl/icr_pkg.sv ====
// constants, types and helpers of the indexed configuration register bank
package icr_pkg;

    // ****************************************************************
    // i/o ports and register indices
    // ****************************************************************
    localparam logic [15:0] IO_INDEX_ADDR     = 16'h00ec;
    localparam logic [15:0] IO_DATA_ADDR      = 16'h00ed;
    localparam logic [15:0] IO_SHORT_MASK     = 16'h03ff;
    localparam logic [7:0]  IDX_PART_ID       = 8'h00;
    localparam logic [7:0]  IDX_COMPATIBILITY_ONES_ONES   = 8'h01;
    localparam logic [7:0]  IDX_SLOT_BOUNDARY = 8'h02;
    localparam logic [7:0]  IDX_DRAM_MAP      = 8'h03;
    localparam logic [7:0]  IDX_RAS_SWAP      = 8'h04;
    localparam logic [7:0]  IDX_DRAM_SETUP    = 8'h05;
    localparam logic [7:0]  IDX_REFRESH_CTL   = 8'h06;
    localparam logic [7:0]  IDX_RAS_TIM_LOW   = 8'h07;
    localparam logic [7:0]  IDX_CAS_TIM_LOW   = 8'h08;
    localparam logic [7:0]  IDX_RAS_TIM_HIGH  = 8'h09;
    localparam logic [7:0]  IDX_CAS_TIM_HIGH  = 8'h0a;
    localparam logic [7:0]  IDX_EMS_UPPER     = 8'h0b;
    localparam logic [7:0]  IDX_EMS_LOWER     = 8'h0c;
    localparam logic [7:0]  IDX_SHADOW_A      = 8'h0d;
    localparam int          REG_COUNT         = 14;
    localparam logic [7:0]  UNMAPPED_READ     = 8'hff;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int MAP_ROM_SLOT_BIT = 7;
    localparam int SET_EARLY_BIT    = 5;
    localparam int REF_DECUP_BIT    = 7;
    localparam int REF_IO10_BIT     = 3;
    localparam int EMS_GLOBAL_BIT   = 7;
    localparam int EMS_BACKFILL_BIT = 6;
    localparam int EMS_MAP_BIT      = 4;

    // ****************************************************************
    // memory ranges, upper address byte
    // ****************************************************************
    localparam logic [7:0] SEG_A  = 8'h0a;
    localparam logic [7:0] SEG_B  = 8'h0b;
    localparam logic [7:0] SEG_E  = 8'h0e;
    localparam logic [7:0] SEG_F  = 8'h0f;
    localparam logic [7:0] SEG_FE = 8'hfe;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } icr_io_req_s;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [23:0] addr;
    } icr_mem_req_s;

    typedef struct packed {
        logic       ras_addsel;
        logic       trcd_long;
        logic [1:0] trp;
        logic [2:0] tras;
        logic [1:0] tcasw;
        logic       tcst_long;
        logic [1:0] tcp;
        logic [1:0] tcasr;
    } icr_timing_s;

    typedef struct packed {
        logic [7:0]  slot_boundary;
        logic        rom_slot;
        logic [4:0]  map_code;
        logic [1:0]  dram_drive;
        logic        early_start_n;
        logic        page_a;
        logic        page_b;
        logic        ilv_a;
        logic        ilv_b;
        logic        ref_decoupled;
        logic [2:0]  ref_div_board;
        logic        io_decode_10;
        logic [2:0]  ref_div_slot;
        icr_timing_s timing_low;
        icr_timing_s timing_high;
        logic        ems_global;
        logic        ems_backfill;
        logic        ems_map;
        logic [11:0] ems_page_en;
        logic [7:0]  shadow_a;
    } icr_cfg_s;

    // ****************************************************************
    // per-register reset value, writable bits and bits read as one
    // ****************************************************************
    function automatic logic [7:0] reg_reset(input logic [7:0] idx);
        case (idx)
            IDX_SLOT_BOUNDARY, IDX_RAS_TIM_LOW, IDX_RAS_TIM_HIGH: reg_reset = 8'hff;
            IDX_DRAM_MAP:                                        reg_reset = 8'he0;
            IDX_RAS_SWAP:                                        reg_reset = 8'hf0;
            IDX_DRAM_SETUP:                                      reg_reset = 8'h3c;
            IDX_CAS_TIM_LOW, IDX_CAS_TIM_HIGH:                   reg_reset = 8'hb7;
            default:                                             reg_reset = 8'h00;
        endcase
    endfunction : reg_reset

    function automatic logic [7:0] reg_wmask(input logic [7:0] idx);
        case (idx)
            IDX_PART_ID, IDX_COMPATIBILITY_ONES_ONES:       reg_wmask = 8'h00;
            IDX_DRAM_MAP:                       reg_wmask = 8'h9f;
            IDX_RAS_SWAP:                       reg_wmask = 8'h0f;
            IDX_DRAM_SETUP:                     reg_wmask = 8'hef;
            IDX_RAS_TIM_LOW, IDX_RAS_TIM_HIGH:  reg_wmask = 8'hdf;
            IDX_CAS_TIM_LOW, IDX_CAS_TIM_HIGH:  reg_wmask = 8'hfb;
            default:                            reg_wmask = 8'hff;
        endcase
    endfunction : reg_wmask

    // strobe i of the internal set that drives external pin sel
    function automatic logic [1:0] swap_select(input logic [3:0] code, input logic [1:0] pin);
        swap_select = (pin + code[3:2]) ^ code[1:0];
    endfunction : swap_select

endpackage : icr_pkg

// ==== sim/icr_host_model.sv ====
// host processor model issuing single byte i/o cycles
`timescale 1ns/1ns
module icr_host_model (
    input  wire logic          CLK_SYS,
    input  wire logic [7:0]    IO_RDATA,
    input  wire logic          IO_RDATA_VALID,
    output icr_pkg::icr_io_req_s IO_REQ
);
    initial IO_REQ = '0;

    // one byte write, request held for one edge, then released
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge CLK_SYS);
        IO_REQ = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge CLK_SYS);
        IO_REQ = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : io_wr

    // one byte read, answer awaited under a bounded count
    task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
        int n;
        @(negedge CLK_SYS);
        IO_REQ = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge CLK_SYS);
        IO_REQ = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'h5a};
        n = 0;
        while (IO_RDATA_VALID !== 1'b1 && n < 4)
        begin
            @(negedge CLK_SYS);
            n++;
        end
        d = (IO_RDATA_VALID === 1'b1) ? IO_RDATA : 8'hxx;
    endtask : io_rd
endmodule : icr_host_model

// ==== sim/testbench.sv ====
// self-checking testbench of the indexed configuration register bank
`timescale 1ns/1ns
module testbench;
    localparam logic [7:0] ID = 8'h56; // arbitrary part code and version
    localparam logic [7:0] RST_TBL [14] = '{8'h56, 8'hff, 8'hff, 8'he0, 8'hf0, 8'h3c, 8'h00,
        8'hff, 8'hb7, 8'hff, 8'hb7, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] ZERO_TBL [14] = '{8'h56, 8'hff, 8'h00, 8'h60, 8'hf0, 8'h10, 8'h00,
        8'h20, 8'h04, 8'h20, 8'h04, 8'h00, 8'h00, 8'h00};
    logic                  clk_sys = 1'b0;
    logic                  rst_n = 1'b0;
    icr_pkg::icr_io_req_s  io_req;
    logic [7:0]            io_rdata;
    logic                  io_rdata_valid;
    icr_pkg::icr_mem_req_s mem_req = '0;
    logic [7:0]            shadow_e = 8'h00;
    logic                  rom_n;
    logic                  slot_sel;
    logic                  board_sel;
    logic [3:0]            ras_int_n = 4'hf;
    logic [3:0]            ras_pin_n;
    icr_pkg::icr_cfg_s     cfg;
    int                    error_cnt = 0;
    int                    n_checks = 0;
    logic [7:0]            v;

    initial forever #4 clk_sys = ~clk_sys;

    icr_config_regs #(.PART_CODE(6'h15), .SILICON_VERSION(2'h2)) icr_config_regs_inst (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .IO_REQ(io_req), .IO_RDATA(io_rdata),
        .IO_RDATA_VALID(io_rdata_valid), .MEM_REQ(mem_req), .SHADOW_E_SEGMENT(shadow_e),
        .ROM_CHIP_SELECT_N(rom_n), .SLOT_BUS_SEL(slot_sel), .BOARD_SEL(board_sel),
        .RAS_BANK_STROBE_INT_N(ras_int_n), .RAS_BANK_STROBE_N(ras_pin_n), .CFG(cfg));

    icr_host_model icr_host_model_inst (
        .CLK_SYS(clk_sys), .IO_RDATA(io_rdata), .IO_RDATA_VALID(io_rdata_valid),
        .IO_REQ(io_req));

    // ****************************************************************
    // shared helpers
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    task automatic do_reset();
        @(negedge clk_sys);
        rst_n = 1'b0;
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
    endtask : do_reset

    task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
        icr_host_model_inst.io_wr(16'h00ec, i);
        icr_host_model_inst.io_wr(16'h00ed, d);
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] i, output logic [7:0] d);
        icr_host_model_inst.io_wr(16'h00ec, i);
        icr_host_model_inst.io_rd(16'h00ed, d);
    endtask : rd_reg

    task automatic mem(input logic r, input logic w, input logic [23:0] a, input logic [2:0] e);
        @(negedge clk_sys);
        mem_req = '{rd: r, wr: w, addr: a};
        @(negedge clk_sys);
        chk({rom_n, slot_sel, board_sel}, e);
    endtask : mem

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset_values();
        for (int i = 0; i < 14; i++)
        begin
            rd_reg(i[7:0], v);
            chk(v, RST_TBL[i]);
        end
        icr_host_model_inst.io_rd(16'h00ec, v);
        chk(v, 8'h0d);
    endtask : t_reset_values

    task automatic t_masks();
        for (int i = 0; i < 14; i++)
        begin
            wr_reg(i[7:0], 8'h00);
            icr_host_model_inst.io_rd(16'h00ed, v);
            chk(v, ZERO_TBL[i]);
            icr_host_model_inst.io_wr(16'h00ed, 8'hff);
            icr_host_model_inst.io_rd(16'h00ed, v);
            chk(v, (i == 0) ? ID : 8'hff);
        end
        rd_reg(8'h0e, v);
        chk(v, 8'hff);
    endtask : t_masks

    task automatic t_swap();
        ras_int_n = 4'he;
        @(negedge clk_sys);
        @(negedge clk_sys);
        chk(ras_pin_n, 4'he);
        wr_reg(8'h04, 8'h04);
        @(negedge clk_sys);
        chk(ras_pin_n, 4'h7);
    endtask : t_swap

    task automatic t_fields();
        wr_reg(8'h02, 8'h3c);
        wr_reg(8'h03, 8'h95);
        wr_reg(8'h05, 8'h9a);
        wr_reg(8'h06, 8'hb2);
        wr_reg(8'h07, 8'h4a);
        wr_reg(8'h08, 8'h49);
        wr_reg(8'h09, 8'h4a);
        wr_reg(8'h0a, 8'h49);
        wr_reg(8'h0b, 8'hd5);
        wr_reg(8'h0c, 8'ha5);
        chk(cfg.slot_boundary, 8'h3c);
        chk({cfg.rom_slot, cfg.map_code, cfg.dram_drive}, 8'hd6);
        chk({cfg.early_start_n, cfg.page_a, cfg.page_b, cfg.ilv_a, cfg.ilv_b}, 5'h0a);
        chk({cfg.ref_decoupled, cfg.ref_div_board, cfg.io_decode_10, cfg.ref_div_slot}, 8'hb2);
        chk(cfg.timing_low, 14'h1525);
        chk(cfg.timing_high, 14'h1525);
        chk({cfg.ems_global, cfg.ems_backfill, cfg.ems_map}, 3'h7);
        chk(cfg.ems_page_en, 12'h5a5);
    endtask : t_fields

    task automatic t_decode();
        icr_host_model_inst.io_wr(16'h00ec, 8'h02);
        icr_host_model_inst.io_wr(16'h04ec, 8'h05);
        icr_host_model_inst.io_rd(16'h00ec, v);
        chk(v, 8'h02);
        wr_reg(8'h06, 8'h08);
        icr_host_model_inst.io_wr(16'h04ec, 8'h05);
        icr_host_model_inst.io_rd(16'h04ec, v);
        chk(v, 8'h05);
        wr_reg(8'h06, 8'h00);
    endtask : t_decode

    task automatic t_mem();
        wr_reg(8'h0d, 8'h0b);
        mem(1'b1, 1'b0, 24'h0e_0000, 3'h0);
        mem(1'b1, 1'b0, 24'hfe_0000, 3'h0);
        mem(1'b1, 1'b0, 24'h0f_0000, 3'h0);
        mem(1'b1, 1'b0, 24'h0a_0000, 3'h5);
        mem(1'b0, 1'b1, 24'h0a_0000, 3'h5);
        mem(1'b0, 1'b1, 24'h0a_4000, 3'h6);
        mem(1'b1, 1'b0, 24'h0a_4000, 3'h5);
        mem(1'b1, 1'b0, 24'h0a_8000, 3'h6);
        shadow_e = 8'h03;
        mem(1'b1, 1'b0, 24'h0e_0000, 3'h5);
        shadow_e = 8'h00;
        wr_reg(8'h03, 8'h00);
        mem(1'b1, 1'b0, 24'h0e_0000, 3'h6);
        mem(1'b1, 1'b0, 24'hfe_0000, 3'h6);
        mem(1'b0, 1'b1, 24'hfe_0000, 3'h6);
        mem(1'b1, 1'b0, 24'h40_0000, 3'h6);
        mem(1'b0, 1'b1, 24'h20_0000, 3'h5);
        mem(1'b0, 1'b0, 24'h00_0000, 3'h4);
    endtask : t_mem

    initial
    begin
        #100000;
        error_cnt++;
        end_of_test();
    end

    initial
    begin
        do_reset();
        t_reset_values();
        t_masks();
        do_reset();
        t_swap();
        t_fields();
        t_decode();
        t_mem();
        end_of_test();
    end
endmodule : testbench
